// [hw/sal_pkg.sv]
//////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: Shared types and constants of the security event audit logger
// Assumes: Non-volatile store is word addressed, one record per word
// Notes:   Critical slots are indexed directly by event category
//////////////////////////////////////////////////////////////////////////////////////////////////
package sal_pkg;

  localparam int SAL_DATE_W     = 16;
  localparam int SAL_TOD_W      = 17;
  localparam int SAL_SUBJ_W     = 8;
  localparam int SAL_ADDR_W     = 6;
  localparam int SAL_GEN_DEPTH  = 32;
  localparam int SAL_CRIT_SLOTS = 16;
  localparam int SAL_LIST_W     = 7;

  // Store map
  localparam logic [SAL_ADDR_W-1:0] SAL_CRIT_BASE = 6'h00;
  localparam logic [SAL_ADDR_W-1:0] SAL_GEN_BASE  = 6'h10;
  localparam logic [SAL_ADDR_W-1:0] SAL_PTR_ADDR  = 6'h30;

  // System subject code and list index after reset
  localparam logic [SAL_SUBJ_W-1:0] SAL_SUBJ_SYSTEM = 8'h00;
  localparam logic [SAL_LIST_W-1:0] SAL_LIST_RESET  = 7'h00;

  // Event category codes
  typedef enum logic [3:0] {
    SAL_EV_AUDIT_START  = 4'h0,
    SAL_EV_AUDIT_STOP   = 4'h1,
    SAL_EV_ADMIN_LOGON  = 4'h2,
    SAL_EV_ADMIN_LOGOFF = 4'h3,
    SAL_EV_PASSWORD     = 4'h4,
    SAL_EV_FACTORY_RST  = 4'h5,
    SAL_EV_FILTER_CFG   = 4'h6,
    SAL_EV_POWER_CYCLE  = 4'h7,
    SAL_EV_SELF_TEST    = 4'h8,
    SAL_EV_TAMPER       = 4'h9,
    SAL_EV_PERM_DISABLE = 4'hA
  } sal_cat_t;

  // Event as offered by the system
  typedef struct packed {
    sal_cat_t                cat;
    logic                    success;
    logic [SAL_SUBJ_W-1:0]   subject;
  } sal_event_t;

  // Stored record; used is zero in an erased word
  typedef struct packed {
    logic                    used;
    logic [SAL_DATE_W-1:0]   date;
    logic [SAL_TOD_W-1:0]    tod;
    logic [SAL_SUBJ_W-1:0]   subject;
    sal_cat_t                cat;
    logic                    success;
  } sal_rec_t;

  localparam int SAL_REC_W = $bits(sal_rec_t);

  function automatic logic sal_is_critical(input sal_cat_t cat);
    return (cat == SAL_EV_FACTORY_RST) || (cat == SAL_EV_SELF_TEST) ||
           (cat == SAL_EV_TAMPER) || (cat == SAL_EV_PERM_DISABLE) ||
           (cat == SAL_EV_PASSWORD);
  endfunction

endpackage

// [hw/sal_audit_log.sv]
//////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: Security event audit logger with critical and general areas in non-volatile store
// Assumes: Date, time of day and events come from logic on clk_sys; shutdown_req is a pin
// Notes:   General ring depth must be a power of two
// Contract
// - Log audit start/stop, admin logon/logoff, filter config, password, factory restore, disable.
// - Audit runs only from power-up to shutdown; no separate enable control.
// - Every event is critical or general, stored in separate areas.
// - Each record holds date, time and subject identity at capture.
// - Each record holds an event category code and a success/failure code.
// - Categories cover logon/logoff, password, factory restore, filter, power cycle, self-test, tamper.
// - Critical events keep only the latest occurrence of each event.
// - General store holds at most thirty-two records.
// - When full, a new general record overwrites the oldest one.
// - Records live in non-volatile memory and survive power loss.
// - Records are returned only after admin logon and then a list command.
// - No erase or delete path; admin access is read only.
//////////////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps

module sal_audit_log
  import sal_pkg::*;
#(
  parameter int GEN_DEPTH = SAL_GEN_DEPTH
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  ev_valid,
  input  wire sal_event_t            ev,
  output logic                       ev_ready,
  input  wire logic [SAL_DATE_W-1:0] date_now,
  input  wire logic [SAL_TOD_W-1:0]  tod_now,
  input  wire logic                  shutdown_req,
  input  wire logic                  admin_logon_ok,
  input  wire logic                  admin_logoff,
  input  wire logic                  list_cmd,
  output logic                       rec_valid,
  output sal_rec_t                   rec_data,
  output logic                       rec_last,
  input  wire logic                  rec_ready,
  output logic                       list_busy,
  output logic                       audit_running,
  output logic                       nvm_req,
  output logic                       nvm_we,
  output logic [SAL_ADDR_W-1:0]      nvm_addr,
  output sal_rec_t                   nvm_wdata,
  input  wire sal_rec_t              nvm_rdata,
  input  wire logic                  nvm_ack
);

  localparam int WPW = $clog2(GEN_DEPTH);

  typedef enum logic [2:0] {S_LOAD, S_IDLE, S_WRITE, S_PTR, S_LREAD, S_LOUT} sal_state_t;

  sal_state_t            state;
  sal_state_t            next_state;
  logic [WPW-1:0]        wp;
  logic                  full;
  logic [SAL_LIST_W-1:0] li;
  logic [SAL_LIST_W-1:0] next_li;
  logic                  next_req;
  logic                  next_we;
  logic [SAL_ADDR_W-1:0] next_addr;
  sal_rec_t              next_wdata;
  logic                  start_pend;
  logic                  stop_pend;
  logic                  stopped;
  logic                  session;
  logic                  list_pend;
  logic                  shut_meta;
  logic                  shut_sync;
  logic                  shut_prev;
  logic                  take_start;
  logic                  take_stop;
  logic                  take_ev;
  logic                  take_list;
  logic                  li_is_last;

  // date, time, subject, category and outcome
  function automatic sal_rec_t mk_rec(input sal_cat_t cat, input logic ok,
                                      input logic [SAL_SUBJ_W-1:0] subj);
    sal_rec_t r;
    r.used    = 1'b1;
    r.date    = date_now;
    r.tod     = tod_now;
    r.subject = subj;
    r.cat     = cat;
    r.success = ok;
    return r;
  endfunction

  // Store address of a list position: critical slots first, then general oldest first
  function automatic logic [SAL_ADDR_W-1:0] list_addr(input logic [SAL_LIST_W-1:0] idx);
    logic [WPW-1:0] g;
    g = WPW'(idx - SAL_LIST_W'(SAL_CRIT_SLOTS));
    if (idx < SAL_LIST_W'(SAL_CRIT_SLOTS)) begin
      return SAL_CRIT_BASE + SAL_ADDR_W'(idx);
    end
    return SAL_GEN_BASE + SAL_ADDR_W'(full ? WPW'(wp + g) : g);
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Arbitration of work taken in idle

  assign take_start = (state == S_IDLE) && start_pend;
  assign take_stop  = (state == S_IDLE) && !start_pend && stop_pend;
  assign take_ev    = (state == S_IDLE) && !start_pend && !stop_pend && !stopped && ev_valid;
  assign take_list  = (state == S_IDLE) && !start_pend && !stop_pend &&
                      !(ev_valid && !stopped) && list_pend;
  assign ev_ready   = (state == S_IDLE) && !start_pend && !stop_pend && !stopped;

  // list spans the critical slots plus at most GEN_DEPTH general ones
  assign li_is_last = (li == SAL_LIST_W'(SAL_CRIT_SLOTS - 1) +
                             (full ? SAL_LIST_W'(GEN_DEPTH) : SAL_LIST_W'(wp)));

  assign list_busy     = (state == S_LREAD) || (state == S_LOUT);
  assign audit_running = !stopped && (state != S_LOAD);

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    sal_rec_t r;
    r          = mk_rec(ev.cat, ev.success, ev.subject);
    next_state = state;
    next_req   = 1'b0;
    next_we    = nvm_we;
    next_addr  = nvm_addr;
    next_wdata = nvm_wdata;
    next_li    = li;
    unique case (state)
      S_LOAD: begin
        next_req  = !nvm_ack;
        next_we   = 1'b0;
        next_addr = SAL_PTR_ADDR;
        if (nvm_ack) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (take_start || take_stop || take_ev) begin
          // audit start and stop logged by the block
          if (take_start) begin
            r = mk_rec(SAL_EV_AUDIT_START, 1'b1, SAL_SUBJ_SYSTEM);
          end else if (take_stop) begin
            r = mk_rec(SAL_EV_AUDIT_STOP, 1'b1, SAL_SUBJ_SYSTEM);
          end
          // one fixed slot per critical category
          next_addr  = sal_is_critical(r.cat) ? SAL_CRIT_BASE + SAL_ADDR_W'(r.cat)
                                              : SAL_GEN_BASE + SAL_ADDR_W'(wp);
          next_wdata = r;
          next_we    = 1'b1;
          next_req   = 1'b1;
          next_state = S_WRITE;
        end else if (take_list) begin
          next_li    = SAL_LIST_RESET;
          next_addr  = list_addr(SAL_LIST_RESET);
          next_we    = 1'b0;
          next_req   = 1'b1;
          next_state = S_LREAD;
        end
      end
      S_WRITE: begin
        next_req = !nvm_ack;
        if (nvm_ack) begin
          if (sal_is_critical(nvm_wdata.cat)) begin
            next_state = S_IDLE;
          end else begin
            // advance past the slot just overwritten
            next_addr  = SAL_PTR_ADDR;
            next_wdata = sal_rec_t'({{(SAL_REC_W - WPW - 1){1'b0}},
                                     full | (wp == WPW'(GEN_DEPTH - 1)), WPW'(wp + 1'b1)});
            next_req   = 1'b1;
            next_state = S_PTR;
          end
        end
      end
      S_PTR: begin
        next_req = !nvm_ack;
        if (nvm_ack) begin
          next_we    = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_LREAD, S_LOUT: begin
        next_req = (state == S_LREAD) && !nvm_ack;
        if ((state == S_LREAD && nvm_ack && nvm_rdata.used)) begin
          next_state = S_LOUT;
        end else if ((state == S_LREAD && nvm_ack) || (state == S_LOUT && rec_ready)) begin
          if (li_is_last) begin
            next_state = S_IDLE;
          end else begin
            next_li    = SAL_LIST_W'(li + 1'b1);
            next_addr  = list_addr(SAL_LIST_W'(li + 1'b1));
            next_req   = 1'b1;
            next_state = S_LREAD;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state     <= S_LOAD;
      nvm_req   <= 1'b0;
      nvm_we    <= 1'b0;
      nvm_addr  <= SAL_PTR_ADDR;
      nvm_wdata <= '0;
      li        <= SAL_LIST_RESET;
    end else begin
      state     <= next_state;
      nvm_req   <= next_req;
      nvm_we    <= next_we;
      nvm_addr  <= next_addr;
      nvm_wdata <= next_wdata;
      li        <= next_li;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // General ring pointer

  // wrap and reload of the ring pointer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wp   <= '0;
      full <= 1'b0;
    end else if (state == S_LOAD && nvm_ack) begin
      {full, wp} <= nvm_rdata[WPW:0];
    end else if (state == S_PTR && nvm_ack) begin
      {full, wp} <= nvm_wdata[WPW:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Power cycle tracking

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shut_meta <= 1'b0;
      shut_sync <= 1'b0;
      shut_prev <= 1'b0;
    end else begin
      shut_meta <= shutdown_req;
      shut_sync <= shut_meta;
      shut_prev <= shut_sync;
    end
  end

  // audit start armed by reset, stop by shutdown
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_pend <= 1'b1;
      stop_pend  <= 1'b0;
      stopped    <= 1'b0;
    end else begin
      if (take_start) begin
        start_pend <= 1'b0;
      end
      if (shut_sync && !shut_prev && !stopped) begin
        stop_pend <= 1'b1;
      end else if (take_stop) begin
        stop_pend <= 1'b0;
      end
      if (take_stop) begin
        stopped <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Administrator access

  // list honoured only inside a logged-on session
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      session   <= 1'b0;
      list_pend <= 1'b0;
    end else begin
      if (admin_logoff) begin
        session <= 1'b0;
      end else if (admin_logon_ok) begin
        session <= 1'b1;
      end
      if (list_cmd && session && !admin_logoff) begin
        list_pend <= 1'b1;
      end else if (take_list || !session) begin
        list_pend <= 1'b0;
      end
    end
  end

  // records presented one at a time
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rec_valid <= 1'b0;
      rec_data  <= '0;
      rec_last  <= 1'b0;
    end else if (state == S_LREAD && nvm_ack && nvm_rdata.used) begin
      rec_valid <= 1'b1;
      rec_data  <= nvm_rdata;
      rec_last  <= li_is_last;
    end else if (state == S_LOUT && rec_ready) begin
      rec_valid <= 1'b0;
      rec_last  <= 1'b0;
    end
  end

endmodule // sal_audit_log

// [tb/sal_audit_log_props.sv]
// Purpose: Port assertions of the audit logger
// Assumes: One clock domain, bound onto the top module
// Notes:   Store, event and list ports
`timescale 1ns/10ps
module sal_audit_log_props
  import sal_pkg::*;
#(
  parameter int GEN_DEPTH = SAL_GEN_DEPTH
) (
  input wire logic                  clk_sys,
  input wire logic                  reset_n,
  input wire logic                  ev_valid,
  input wire sal_event_t            ev,
  input wire logic                  ev_ready,
  input wire logic [SAL_DATE_W-1:0] date_now,
  input wire logic [SAL_TOD_W-1:0]  tod_now,
  input wire logic                  rec_valid,
  input wire sal_rec_t              rec_data,
  input wire logic                  rec_last,
  input wire logic                  rec_ready,
  input wire logic                  audit_running,
  input wire logic                  nvm_req,
  input wire logic                  nvm_we,
  input wire logic [SAL_ADDR_W-1:0] nvm_addr,
  input wire sal_rec_t              nvm_wdata,
  input wire logic                  nvm_ack
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic [4:0] wp;
  logic       wr;
  assign wr = nvm_req && nvm_we;
  // Ring slot of the last completed access
  always_ff @(posedge clk_sys) begin
    if (nvm_req && nvm_ack) begin
      wp <= 5'(nvm_addr - SAL_GEN_BASE);
    end
  end
  sequence s_rec_done;
    wr && nvm_ack && nvm_addr >= SAL_GEN_BASE && nvm_addr < SAL_PTR_ADDR;
  endsequence
  sequence s_ptr_wr;
    ##[1:2] wr && nvm_addr == SAL_PTR_ADDR && nvm_wdata[4:0] == 5'((wp + 1) % GEN_DEPTH);
  endsequence
  a_req_holds_access:
    assert property (nvm_req && !nvm_ack |=> nvm_req && $stable({nvm_we, nvm_addr, nvm_wdata}))
    else $error("store request changed before ack");
  a_no_erase_word:
    assert property (wr && nvm_addr != SAL_PTR_ADDR |-> nvm_wdata.used)
    else $error("record written as erased");
  a_crit_own_slot:
    assert property (wr && nvm_addr < SAL_GEN_BASE |-> nvm_addr[3:0] == nvm_wdata.cat
      && nvm_wdata.cat inside {SAL_EV_PASSWORD, SAL_EV_FACTORY_RST, SAL_EV_SELF_TEST,
      SAL_EV_TAMPER, SAL_EV_PERM_DISABLE})
    else $error("critical slot mismatch");
  a_ptr_after_rec:
    assert property (s_rec_done |-> s_ptr_wr)
    else $error("pointer not written after record");
  a_capture_now:
    assert property (ev_valid && ev_ready |=> wr && nvm_wdata == {1'b1, $past(date_now),
      $past(tod_now), $past(ev.subject), $past(ev.cat), $past(ev.success)})
    else $error("captured record wrong");
  a_ready_needs_run:
    assert property (ev_ready |-> audit_running && !nvm_req)
    else $error("event taken while audit stopped or store busy");
  a_rec_held:
    assert property (rec_valid && !rec_ready |=> rec_valid && $stable({rec_data, rec_last}))
    else $error("record dropped before ready");
  a_rec_used:
    assert property (rec_valid |-> rec_data.used)
    else $error("erased word listed");
endmodule // sal_audit_log_props

bind sal_audit_log sal_audit_log_props #(.GEN_DEPTH(GEN_DEPTH)) sal_audit_log_props_inst (.*);

// [tb/sal_nvm_model.sv]
// Purpose: Non-volatile record store beside the logger
// Assumes: One access at a time, ack after 1 to 3 cycles
// Notes:   No reset input; contents outlive the logger reset
`timescale 1ns/10ps
module sal_nvm_model
  import sal_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  nvm_req,
  input  wire logic                  nvm_we,
  input  wire logic [SAL_ADDR_W-1:0] nvm_addr,
  input  wire sal_rec_t              nvm_wdata,
  output sal_rec_t                   nvm_rdata,
  output logic                       nvm_ack
);
  sal_rec_t mem [64] = '{default: '0};
  int       wait_n   = 0;
  initial begin
    nvm_rdata = '0;
    nvm_ack = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (nvm_ack) begin
      nvm_ack <= #1 1'b0;
      nvm_rdata <= #1 ~nvm_rdata;
    end else if (nvm_req && wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (nvm_req) begin
      nvm_ack <= #1 1'b1;
      wait_n <= $urandom % 3;
      if (nvm_we) mem[nvm_addr] <= nvm_wdata;
      else nvm_rdata <= #1 mem[nvm_addr];
    end
  end
endmodule // sal_nvm_model

// [tb/security_event_audit_log_bench.sv]
// Purpose: Self-checking bench of the audit logger
// Assumes: Store model keeps contents across reset
// Notes:   Expected log is rebuilt from a queue model
`timescale 1ns/10ps
module security_event_audit_log_bench;
  import sal_pkg::*;
  logic                  clk_sys        = 1'b0;
  logic                  reset_n        = 1'b0;
  logic                  ev_valid       = 1'b0;
  sal_event_t            ev             = '0;
  logic [SAL_DATE_W-1:0] date_now       = 16'h1234;
  logic [SAL_TOD_W-1:0]  tod_now        = 17'h00000;
  logic                  shutdown_req   = 1'b0;
  logic                  admin_logon_ok = 1'b0;
  logic                  admin_logoff   = 1'b0;
  logic                  list_cmd       = 1'b0;
  logic                  rec_ready      = 1'b0;
  logic                  ev_ready, rec_valid, rec_last, list_busy, audit_running;
  logic                  nvm_req, nvm_we, nvm_ack;
  logic [SAL_ADDR_W-1:0] nvm_addr;
  sal_rec_t              rec_data, nvm_wdata, nvm_rdata;
  sal_rec_t              crit [16] = '{default: '0};
  sal_rec_t              gen_q [$];
  sal_rec_t              exp_q [$];
  sal_rec_t              got_q [$];
  int                    bad_count = 0;
  int                    checks    = 0;

  sal_audit_log sal_audit_log_inst (.*);
  sal_nvm_model sal_nvm_model_inst (.*);

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tod_now <= #1 tod_now + 17'h00001;
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail_to(string what);
    bad_count++;
    $display("Error %s wait expired", what);
    final_report();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  // Start and stop records carry a time of day that the bench does not track
  function automatic sal_rec_t msk(sal_rec_t r);
    if (r.cat inside {SAL_EV_AUDIT_START, SAL_EV_AUDIT_STOP}) begin
      r.tod = '0;
    end
    return r;
  endfunction
  function automatic sal_rec_t mk(sal_cat_t c, logic s, logic [7:0] sj, logic [16:0] t);
    return '{1'b1, date_now, t, sj, c, s};
  endfunction
  task automatic add(sal_rec_t r);
    if (r.cat inside {SAL_EV_PASSWORD, SAL_EV_FACTORY_RST, SAL_EV_SELF_TEST, SAL_EV_TAMPER,
        SAL_EV_PERM_DISABLE}) begin
      crit[r.cat] = r;
    end else begin
      gen_q.push_back(r);
      if (gen_q.size() > 32) gen_q.pop_front();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic power_up();
    reset_n = 1'b0;
    repeat (16) tick();
    check("reset addr", nvm_addr, SAL_PTR_ADDR);
    reset_n = 1'b1;
    tick();
    check("ptr read", {nvm_req, nvm_we, nvm_addr}, {2'b10, SAL_PTR_ADDR});
    add(mk(SAL_EV_AUDIT_START, 1'b1, SAL_SUBJ_SYSTEM, '0));
  endtask
  task automatic send(sal_cat_t c);
    int                   n;
    logic [SAL_TOD_W-1:0] t;
    tick();
    ev = '{c, 1'($urandom), 8'($urandom)};
    date_now = 16'($urandom);
    ev_valid = 1'b1;
    for (n = 0; n < 400; n++) begin
      @(negedge clk_sys);
      if (ev_ready === 1'b1) break;
    end
    if (n == 400) fail_to("ev_ready");
    t = tod_now;
    tick();
    ev_valid = 1'b0;
    add(mk(c, ev.success, ev.subject, t));
  endtask
  task automatic no_list();
    logic seen;
    seen = 1'b0;
    pulse(list_cmd);
    repeat (20) begin
      seen |= list_busy;
      tick();
    end
    check("list ignored", seen, 1'b0);
  endtask
  task automatic do_list();
    int   n;
    logic done;
    got_q.delete();
    exp_q.delete();
    for (int i = 0; i < 16; i++) if (crit[i].used) exp_q.push_back(crit[i]);
    foreach (gen_q[i]) exp_q.push_back(gen_q[i]);
    pulse(list_cmd);
    done = 1'b0;
    for (n = 0; n < 4000 && !done; n++) begin
      rec_ready = 1'($urandom);
      @(negedge clk_sys);
      if (rec_valid === 1'b1 && rec_ready) begin
        got_q.push_back(rec_data);
        done = (rec_last === 1'b1);
      end
      tick();
    end
    rec_ready = 1'b0;
    if (!done) fail_to("rec_last");
    check("list size", got_q.size(), exp_q.size());
    foreach (exp_q[i]) check("record", msk(got_q[i]), msk(exp_q[i]));
  endtask
  task automatic stop_audit();
    int   n;
    logic seen;
    shutdown_req = 1'b1;
    add(mk(SAL_EV_AUDIT_STOP, 1'b1, SAL_SUBJ_SYSTEM, '0));
    for (n = 0; n < 300 && (audit_running !== 1'b0 || nvm_req !== 1'b0); n++) tick();
    if (n == 300) fail_to("audit stop");
    ev_valid = 1'b1;
    seen = 1'b0;
    repeat (20) begin
      seen |= ev_ready;
      tick();
    end
    check("ready after stop", seen, 1'b0);
    ev_valid = 1'b0;
    shutdown_req = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(96197));
    power_up();
    no_list();
    for (int c = 2; c <= 10; c++) send(sal_cat_t'(c));
    pulse(admin_logon_ok);
    do_list();
    repeat (80) send(sal_cat_t'(2 + $urandom % 9));
    do_list();
    pulse(admin_logoff);
    no_list();
    stop_audit();
    power_up();
    pulse(admin_logon_ok);
    do_list();
    final_report();
  end
endmodule // security_event_audit_log_bench
